// ### src/cbrs_bit_timing.sv
/*
  bit_time_engine of a CAN protocol controller: walks the bit time once per
  time_quantum, detects recessive-to-dominant edges, applies hard sync or
  bounded resync and hands the sampled bit to the frame_bit_engine.
  assumes the frame_bit_engine runs on mclk and drives hard_sync_sel, and
  that software keeps max_jump_quanta within both phase buffers.
*/
// Chosen here: strobed register access and the address map.
// Functional notes
// RULE1: only recessive-to-dominant edges synchronise
// RULE2: sample each quantum, compare with last sample
// RULE3: edge in sync slot has zero error
// RULE4: hard sync at frame start, else resync
// RULE5: hard sync restarts bit after sync slot
// RULE6: late edge lengthens pre buffer, capped
// RULE7: early edge shortens post buffer, capped
// RULE8: one synchronisation between two sample points
// RULE9: stretched buffers revert next bit
// RULE10: early edge resync skips next sync slot
// RULE11: synchronisation filters short dominant spikes
// RULE12: software keeps jump within both buffers
// RULE13: software meets both oscillator tolerance limits
// RULE14: best tolerance setting suits slow short buses
// RULE15: quantum is mclk divided by 1..32
// RULE16: sync one quantum, segments 1..8, jump 1..4
// RULE17: single sample, no three-sample filter
// RULE18: engine steps per quantum, frame engine selects
// RULE19: sample at end of stretched pre buffer
`timescale 1ns/1ns
module cbrs_bit_timing
  import cbrs_pkg::*;
(
  input  wire logic        mclk,           // system clock, 250 MHz
  input  wire logic        rstn,           // async reset, active low
  input  wire logic        rx_pin,         // bus level from transceiver, 1 = recessive
  input  wire logic        hard_sync_sel,  // frame engine: next edge is a frame start
  input  wire logic [7:0]  reg_addr,       // register byte address
  input  wire logic [31:0] reg_wdata,      // register write data
  input  wire logic        reg_wr,         // write strobe
  input  wire logic        reg_rd,         // read strobe
  output logic      [31:0] reg_rdata,      // read data, cycle after reg_rd
  output logic             sample_pulse,   // one-cycle pulse at each sample point
  output logic             sample_bit,     // level taken at the last sample point
  output logic             sync_pulse      // one-cycle pulse on each synchronisation
);

  // configuration registers
  logic [4:0] div_m1_r;   // quantum_divider minus one
  logic [1:0] jump_m1_r;  // max_jump_quanta minus one
  logic [2:0] prop_m1_r;  // delay compensation span minus one
  logic [2:0] pb1_m1_r;   // pre_sample_buffer minus one
  logic [2:0] pb2_m1_r;   // post_sample_buffer minus one
  logic       enable_r;   // engine running

  // engine state
  cbrs_seg_t  seg_r;      // current segment
  logic [3:0] cnt_r;      // quanta already spent in the segment
  logic [3:0] pb1_lim_r;  // pre buffer length for this bit
  logic [3:0] pb2_lim_r;  // post buffer length for this bit
  logic       last_smp_r; // level at the previous sample point
  logic       synced_r;   // a synchronisation was done since the sample point

  // nominal lengths in quanta
  logic [3:0] prop_len;
  logic [3:0] pb1_len;
  logic [3:0] pb2_len;
  logic [3:0] jump_len;

  // edge and error terms
  logic       edge_ok;    // qualifying edge in this quantum
  logic       hard_now;   // edge handled as hard sync
  logic       resync_now; // edge handled as resync
  logic [3:0] pos_err;    // late edge phase error
  logic [4:0] pos_sum;    // late edge error before the clamp
  logic [3:0] neg_err;    // early edge phase error magnitude
  logic [3:0] pb1_eff;    // pre buffer length including this quantum's stretch
  logic       at_sample;  // this quantum ends the pre buffer
  logic       early_full; // early edge fully compensated

  cbrs_tq_if tq ();  // quantum strobe and per-quantum level

  // front end: divider and bus sampler
  cbrs_quantum_divider u_div (
    .mclk   (mclk),
    .rstn   (rstn),
    .enable (enable_r),
    .div_m1 (div_m1_r),
    .tq     (tq)
  );

  cbrs_rx_sampler u_rx (
    .mclk   (mclk),
    .rstn   (rstn),
    .rx_pin (rx_pin),
    .tq     (tq)
  );

  // segment lengths; sync slot is fixed at one quantum
  assign prop_len = cbrs_len3(prop_m1_r);            // [RULE16]
  assign pb1_len  = cbrs_len3(pb1_m1_r);             // [RULE16]
  assign pb2_len  = cbrs_len3(pb2_m1_r);             // [RULE16]
  assign jump_len = {2'h0, jump_m1_r} + `CBRS_ONE_Q;  // [RULE16]

  // edge: bus dominant now while the last sample point saw recessive;
  // a rising level back to recessive can never pass this test
  assign edge_ok = tq.tq_en && enable_r && !tq.bus_level
                   && last_smp_r && !synced_r;  // [RULE1] [RULE2] [RULE8]

  // frame engine chooses the kind of synchronisation
  assign hard_now   = edge_ok && hard_sync_sel;   // [RULE4] [RULE18]
  assign resync_now = edge_ok && !hard_sync_sel;  // [RULE4]

  // late edge: quanta from the end of the sync slot up to and including
  // the edge quantum
  always_comb begin
    if (seg_r == CBRS_PROP) begin
      pos_sum = {1'b0, cnt_r} + {1'b0, `CBRS_ONE_Q};  // [RULE3]
    end else begin
      pos_sum = {1'b0, prop_len} + {1'b0, cnt_r} + {1'b0, `CBRS_ONE_Q};  // [RULE3]
    end
    // long spans reach 16 quanta; clamp rather than wrap, any such error
    // is beyond the largest jump anyway
    pos_err = {4{pos_sum[4]}} | pos_sum[3:0];
  end

  // early edge: quanta left before the next sync slot would end
  assign neg_err    = pb2_lim_r - cnt_r;  // [RULE3]
  assign early_full = (neg_err <= jump_len);

  // stretch the pre buffer in the very quantum of a late edge so the sample
  // point moves this bit; excess error beyond the jump stays
  always_comb begin
    if (resync_now && (seg_r == CBRS_PROP || seg_r == CBRS_PB1)) begin
      pb1_eff = pb1_lim_r + cbrs_min_q(pos_err, jump_len);  // [RULE6] [RULE11]
    end else begin
      pb1_eff = pb1_lim_r;
    end
  end

  // sample point sits on the last quantum of the stretched pre buffer
  assign at_sample = tq.tq_en && enable_r && !hard_now && (seg_r == CBRS_PB1)
                     && (cnt_r == pb1_eff - `CBRS_ONE_Q);  // [RULE19]

  // segment walk, one step per quantum; reset to sync slot while disabled
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      seg_r <= CBRS_SYNC;
      cnt_r <= `CBRS_ZERO_Q;
    end else if (!enable_r) begin
      seg_r <= CBRS_SYNC;
      cnt_r <= `CBRS_ZERO_Q;
    end else if (hard_now) begin
      // edge quantum counts as the sync slot, whatever its phase error
      seg_r <= CBRS_PROP;  // [RULE5]
      cnt_r <= `CBRS_ZERO_Q;  // [RULE5]
    end else if (tq.tq_en) begin
      case (seg_r)
        CBRS_SYNC: begin
          // an edge here is on time and changes nothing
          seg_r <= CBRS_PROP;  // [RULE3]
          cnt_r <= `CBRS_ZERO_Q;
        end
        CBRS_PROP: begin
          if (cnt_r == prop_len - `CBRS_ONE_Q) begin
            seg_r <= CBRS_PB1;
            cnt_r <= `CBRS_ZERO_Q;
          end else begin
            cnt_r <= cnt_r + `CBRS_ONE_Q;
          end
        end
        CBRS_PB1: begin
          if (at_sample) begin
            seg_r <= CBRS_PB2;  // [RULE19]
            cnt_r <= `CBRS_ZERO_Q;
          end else begin
            cnt_r <= cnt_r + `CBRS_ONE_Q;
          end
        end
        CBRS_PB2: begin
          if (resync_now && early_full) begin
            // bit ends at the edge; the edge quantum stands in for the
            // sync slot, which is therefore skipped
            seg_r <= CBRS_PROP;  // [RULE7] [RULE10]
            cnt_r <= `CBRS_ZERO_Q;
          end else if (resync_now
                       && cnt_r == pb2_lim_r - jump_len - `CBRS_ONE_Q) begin
            seg_r <= CBRS_SYNC;  // [RULE7]
            cnt_r <= `CBRS_ZERO_Q;
          end else if (!resync_now && cnt_r == pb2_lim_r - `CBRS_ONE_Q) begin
            seg_r <= CBRS_SYNC;
            cnt_r <= `CBRS_ZERO_Q;
          end else begin
            cnt_r <= cnt_r + `CBRS_ONE_Q;
          end
        end
        default: begin
          seg_r <= CBRS_SYNC;
          cnt_r <= `CBRS_ZERO_Q;
        end
      endcase
    end
  end

  // per-bit buffer lengths: stretched by resync, back to nominal each bit
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pb1_lim_r <= `CBRS_ONE_Q;
      pb2_lim_r <= `CBRS_ONE_Q;
    end else if (!enable_r || hard_now) begin
      pb1_lim_r <= pb1_len;  // [RULE5]
      pb2_lim_r <= pb2_len;
    end else if (at_sample) begin
      // post buffer of this bit starts nominal
      pb1_lim_r <= pb1_len;  // [RULE9]
      pb2_lim_r <= pb2_len;  // [RULE9]
    end else if (resync_now && seg_r == CBRS_PB2 && early_full) begin
      pb2_lim_r <= pb2_len;  // [RULE9]
    end else if (resync_now && seg_r == CBRS_PB2) begin
      // partial correction: shorten by the full jump, error remains
      pb2_lim_r <= pb2_lim_r - jump_len;  // [RULE7]
    end else if (tq.tq_en) begin
      pb1_lim_r <= pb1_eff;  // [RULE6]
    end
  end

  // sample capture and the one-sync-per-bit lock; a sync and a sample
  // point never share a quantum, so the capture and clear cannot be lost to the set
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      last_smp_r <= `CBRS_RECESSIVE;
      synced_r   <= 1'b0;
    end else if (!enable_r) begin
      last_smp_r <= `CBRS_RECESSIVE;
      synced_r   <= 1'b0;
    end else if (edge_ok) begin
      synced_r <= 1'b1;  // [RULE8]
    end else if (at_sample) begin
      last_smp_r <= tq.bus_level;  // [RULE2] [RULE17]
      synced_r   <= 1'b0;  // [RULE8]
    end
  end

  // outputs to the frame_bit_engine
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sample_pulse <= 1'b0;
      sample_bit   <= `CBRS_RECESSIVE;
      sync_pulse   <= 1'b0;
    end else begin
      sample_pulse <= at_sample;  // [RULE19]
      sync_pulse   <= edge_ok;
      if (at_sample) begin
        sample_bit <= tq.bus_level;  // [RULE11] [RULE19]
      end
    end
  end

  // register writes; fields hold length minus one, so any value is legal
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      div_m1_r  <= `CBRS_DIV_RST;
      jump_m1_r <= `CBRS_JUMP_RST;
      prop_m1_r <= `CBRS_SEG_RST;
      pb1_m1_r  <= `CBRS_SEG_RST;
      pb2_m1_r  <= `CBRS_SEG_RST;
      enable_r  <= 1'b0;
    end else if (reg_wr) begin
      case (reg_addr)
        `CBRS_TIMING_ADDR: begin
          div_m1_r  <= reg_wdata[`CBRS_DIV_MSB:`CBRS_DIV_LSB];  // [RULE15]
          jump_m1_r <= reg_wdata[`CBRS_JUMP_MSB:`CBRS_JUMP_LSB];
          prop_m1_r <= reg_wdata[`CBRS_PROP_MSB:`CBRS_PROP_LSB];
          pb1_m1_r  <= reg_wdata[`CBRS_PB1_MSB:`CBRS_PB1_LSB];
          pb2_m1_r  <= reg_wdata[`CBRS_PB2_MSB:`CBRS_PB2_LSB];
        end
        `CBRS_CONTROL_ADDR: begin
          enable_r <= reg_wdata[`CBRS_CTL_ENABLE];
        end
        default: begin
          enable_r <= enable_r;  // unmapped and read-only offsets ignore writes
        end
      endcase
    end
  end

  // read data stands only in the cycle after the strobe; unmapped reads 0
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= 32'h0000_0000;
      case (reg_addr)
        `CBRS_TIMING_ADDR: begin
          reg_rdata[`CBRS_DIV_MSB:`CBRS_DIV_LSB]   <= div_m1_r;
          reg_rdata[`CBRS_JUMP_MSB:`CBRS_JUMP_LSB] <= jump_m1_r;
          reg_rdata[`CBRS_PROP_MSB:`CBRS_PROP_LSB] <= prop_m1_r;
          reg_rdata[`CBRS_PB1_MSB:`CBRS_PB1_LSB]   <= pb1_m1_r;
          reg_rdata[`CBRS_PB2_MSB:`CBRS_PB2_LSB]   <= pb2_m1_r;
        end
        `CBRS_CONTROL_ADDR: begin
          reg_rdata[`CBRS_CTL_ENABLE] <= enable_r;
        end
        `CBRS_STATUS_ADDR: begin
          reg_rdata[`CBRS_STS_SAMPLE] <= last_smp_r;
          reg_rdata[`CBRS_STS_SYNCED] <= synced_r;
          reg_rdata[`CBRS_STS_STATE_MSB:`CBRS_STS_STATE_LSB] <= seg_r;
        end
        default: begin
          reg_rdata <= 32'h0000_0000;
        end
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule : cbrs_bit_timing

// ### src/cbrs_defines.svh
/*
  register offsets, field positions and reset values of the bit timing
  synchroniser. assumes it is included by bare name from the package only;
  definitions only.
*/
`ifndef CBRS_DEFINES_SVH
`define CBRS_DEFINES_SVH

// register byte offsets
`define CBRS_TIMING_ADDR   8'h00
`define CBRS_CONTROL_ADDR  8'h04
`define CBRS_STATUS_ADDR   8'h08

// timing register fields, each holds length minus one
`define CBRS_DIV_LSB       0
`define CBRS_DIV_MSB       4
`define CBRS_JUMP_LSB      5
`define CBRS_JUMP_MSB      6
`define CBRS_PROP_LSB      8
`define CBRS_PROP_MSB      10
`define CBRS_PB1_LSB       12
`define CBRS_PB1_MSB       14
`define CBRS_PB2_LSB       16
`define CBRS_PB2_MSB       18

// control and status bits
`define CBRS_CTL_ENABLE    0
`define CBRS_STS_SAMPLE    0
`define CBRS_STS_SYNCED    1
`define CBRS_STS_STATE_LSB 2
`define CBRS_STS_STATE_MSB 3

// reset values of the length-minus-one fields
`define CBRS_DIV_RST       5'h00
`define CBRS_JUMP_RST      2'h0
`define CBRS_SEG_RST       3'h0

// small constants
`define CBRS_ONE_Q         4'h1
`define CBRS_ZERO_Q        4'h0
`define CBRS_RECESSIVE     1'b1

`endif

// ### src/cbrs_pkg.sv
/*
  types shared by the bit timing synchroniser modules.
  assumes cbrs_defines.svh is on the include path.
*/
package cbrs_pkg;
  `include "cbrs_defines.svh"

  // bit time segments as walked by the bit_time_engine
  typedef enum logic [1:0] {
    CBRS_SYNC,
    CBRS_PROP,
    CBRS_PB1,
    CBRS_PB2
  } cbrs_seg_t;

  // length in quanta of a 3-bit length-minus-one field
  function automatic logic [3:0] cbrs_len3(input logic [2:0] m1);
    cbrs_len3 = {1'b0, m1} + `CBRS_ONE_Q;
  endfunction : cbrs_len3

  // smaller of a phase error and the jump limit
  function automatic logic [3:0] cbrs_min_q(input logic [3:0] a, input logic [3:0] b);
    cbrs_min_q = (a < b) ? a : b;
  endfunction : cbrs_min_q
endpackage : cbrs_pkg

// ### src/cbrs_tq_if.sv
/*
  carries the time_quantum strobe and the per-quantum bus level from the
  front-end modules to the bit_time_engine. one clock domain (mclk).
*/
`timescale 1ns/1ns
interface cbrs_tq_if;
  logic tq_en;      // one-cycle pulse, one per time_quantum
  logic bus_level;  // bus level taken in the current quantum, 1 = recessive

  modport div_src (output tq_en);
  modport lvl_src (input tq_en, output bus_level);
  modport engine  (input tq_en, input bus_level);
endinterface : cbrs_tq_if

// ### src/cbrs_quantum_divider.sv
/*
  quantum_divider: divides mclk by the programmed value (1..32) into a
  one-cycle time_quantum enable. assumes div_m1 is stable while enabled.
*/
`timescale 1ns/1ns
module cbrs_quantum_divider
  import cbrs_pkg::*;
(
  input  wire logic       mclk,    // system clock
  input  wire logic       rstn,    // async reset, active low
  input  wire logic       enable,  // divider runs only while high
  input  wire logic [4:0] div_m1,  // divide value minus one
  cbrs_tq_if.div_src      tq       // quantum strobe out
);
  logic [4:0] cnt_r;  // mclk cycles into the current quantum

  // count up to div_m1 and wrap; held at zero while idle so the first
  // quantum after enabling is a full one
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 5'h00;
    end else if (!enable || cnt_r == div_m1) begin
      cnt_r <= 5'h00;  // [RULE15]
    end else begin
      cnt_r <= cnt_r + 5'h01;
    end
  end

  // strobe on the last cycle of each quantum
  assign tq.tq_en = enable && (cnt_r == div_m1);  // [RULE15]
endmodule : cbrs_quantum_divider

// ### src/cbrs_rx_sampler.sv
/*
  brings the received bus pin into the mclk domain and takes one level per
  time_quantum. assumes rx_pin is asynchronous to mclk.
*/
`timescale 1ns/1ns
module cbrs_rx_sampler
  import cbrs_pkg::*;
(
  input  wire logic  mclk,    // system clock
  input  wire logic  rstn,    // async reset, active low
  input  wire logic  rx_pin,  // raw bus level from transceiver
  cbrs_tq_if.lvl_src tq       // quantum strobe in, level out
);
  logic meta_r;  // first synchroniser stage, read only by sync_r
  logic sync_r;  // second stage, safe to use

  // two-stage synchroniser; both idle recessive
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= `CBRS_RECESSIVE;
      sync_r <= `CBRS_RECESSIVE;
    end else begin
      meta_r <= rx_pin;
      sync_r <= meta_r;
    end
  end

  // one sample per quantum; a single sample, no majority vote
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tq.bus_level <= `CBRS_RECESSIVE;
    end else if (tq.tq_en) begin
      tq.bus_level <= sync_r;  // [RULE2] [RULE17]
    end
  end
endmodule : cbrs_rx_sampler

// ### sim/cbrs_bus_node.sv
/*
  stand-in for the bus as seen through the transceiver: one node whose
  level the bench steps. assumes drive() is called from one process only.
*/
`timescale 1ns/1ns
module cbrs_bus_node (
  input  wire logic mclk,   // bench clock, paces level changes
  output logic      rx_pin  // received level, 1 = recessive
);
  // idle bus rests recessive through the termination
  initial rx_pin = 1'b1;

  // launch just after an edge so the sampler never sees a half-step
  task automatic drive(input logic lvl);
    @(posedge mclk);
    rx_pin <= lvl;
  endtask : drive
endmodule : cbrs_bus_node

// ### sim/cbrs_bit_timing_monitor.sv
/*
  port checker for the bit timing synchroniser.
  assumes one mclk domain and the control word at byte offset 0x04.
*/
`timescale 1ns/1ns
module cbrs_bit_timing_monitor (
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        rx_pin,
  input wire logic        hard_sync_sel,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        sample_pulse,
  input wire logic        sample_bit,
  input wire logic        sync_pulse
);
  logic en_r;      // mirrored enable bit
  logic synced_r;  // a sync seen since the last sample point

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // mirror of the enable bit, lands at the write edge like the design
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      en_r <= 1'b0;
    end else if (reg_wr && reg_addr == 8'h04) begin
      en_r <= reg_wdata[0];
    end
  end

  // sample point clears first: a sync may never share its cycle
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      synced_r <= 1'b0;
    end else if (sample_pulse) begin
      synced_r <= 1'b0;
    end else if (sync_pulse) begin
      synced_r <= 1'b1;
    end
  end

  AST_ONE_SYNC: assert property (sync_pulse |-> !synced_r)
    else $error("second sync before sample point");
  AST_SYNC_FROM_REC: assert property (sync_pulse && !sample_pulse |-> sample_bit)
    else $error("sync after a dominant sample");
  AST_SYNC_THEN_SAMPLE: assert property (sync_pulse |-> ##[1:660] sample_pulse)
    else $error("no sample point after sync");
  AST_SAMPLE_GAP: assert property (sample_pulse |=> !sample_pulse [*2])
    else $error("sample points too close");
  AST_BIT_HOLD: assert property (!sample_pulse |-> $stable(sample_bit))
    else $error("sampled level moved off sample point");
  AST_RUNS: assert property (en_r && sample_pulse |-> ##[3:930] (sample_pulse || !en_r))
    else $error("bit time overran");
  AST_QUIET_OFF: assert property (!en_r [*3] |-> !sample_pulse && !sync_pulse)
    else $error("activity while disabled");
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  AST_RD_CTL: assert property (reg_rd && reg_addr == 8'h04 |=> reg_rdata == {31'h0, $past(en_r)})
    else $error("control readback wrong");
  AST_RD_GAP: assert property (reg_rd && reg_addr == 8'h0c |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
endmodule : cbrs_bit_timing_monitor

bind cbrs_bit_timing cbrs_bit_timing_monitor u_mon (
  .mclk(mclk), .rstn(rstn), .rx_pin(rx_pin), .hard_sync_sel(hard_sync_sel),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .sample_pulse(sample_pulse), .sample_bit(sample_bit),
  .sync_pulse(sync_pulse)
);

// ### sim/tb.sv
/*
  self-checking bench of the bit timing synchroniser: register port,
  nominal bit length and synchronisation on every quantum of a bit.
  assumes the bus node stand-in and the bound checker are compiled in.
*/
`timescale 1ns/1ns
module tb;
  logic        mclk, rstn, rx_pin, hard_sync_sel;  // clock, reset, bus, frame select
  logic        reg_wr, reg_rd;                     // register strobes
  logic [7:0]  reg_addr;                           // register address
  logic [31:0] reg_wdata, reg_rdata;               // register data
  logic        sample_pulse, sample_bit, sync_pulse;
  int          n_mismatch, checked, n_sync;        // verdict counters

  cbrs_bit_timing dut (.mclk(mclk), .rstn(rstn), .rx_pin(rx_pin),
    .hard_sync_sel(hard_sync_sel), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sample_pulse(sample_pulse), .sample_bit(sample_bit), .sync_pulse(sync_pulse));
  cbrs_bus_node node (.mclk(mclk), .rx_pin(rx_pin));

  // 250 MHz
  always #2 mclk = ~mclk;

  // counted off the edge so the registered pulse has settled
  always @(negedge mclk) begin
    if (sync_pulse === 1'b1) begin
      n_sync++;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : reg_write

  // data stands only in the cycle after the strobe, so look mid-cycle
  task automatic reg_check(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    check(reg_rdata, exp);
  endtask : reg_check

  // cycles until the chosen pulse; a lost pulse ends the run
  task automatic wait_for(input bit use_sync, output int n);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while ((use_sync ? sync_pulse : sample_pulse) !== 1'b1 && n < 1000);
    if (n >= 1000) begin
      n_mismatch++;
      conclude();
    end
  endtask : wait_for

  task automatic t_regs();
    reg_check(8'h00, 32'h0);
    reg_check(8'h04, 32'h0);
    reg_write(8'h08, 32'hffffffff);
    reg_check(8'h08, 32'h1);
    reg_check(8'h0c, 32'h0);
    reg_write(8'h00, 32'h0007_777f);
    reg_check(8'h00, 32'h0007_777f);
    reg_write(8'h00, 32'h0003_3060);
    reg_check(8'h00, 32'h0003_3060);
  endtask : t_regs

  // 1+1+2+2 quanta per bit, quantum of div+1 clocks
  task automatic t_period(input logic [4:0] div);
    int n;
    reg_write(8'h04, 32'h0);
    reg_write(8'h00, 32'h0001_1020 | {27'h0, div});
    reg_write(8'h04, 32'h1);
    wait_for(0, n);
    wait_for(0, n);
    check(n, 6 * (int'(div) + 1));
    check({31'h0, sample_bit}, 32'h1);
  endtask : t_period

  // one edge in each quantum of the bit; distance sync to sample summed
  task automatic t_sweep(input logic [31:0] tim, input logic hs, input int es,
                         input int emn, input int emx, input logic spk);
    int n, d, s0, sum, mn, mx;
    sum = 0;
    mn = 99;
    mx = 0;
    reg_write(8'h04, 32'h0);
    reg_write(8'h00, tim);
    reg_write(8'h04, 32'h1);
    @(posedge mclk);
    hard_sync_sel <= hs;
    for (int k = 0; k < 6; k++) begin
      wait_for(0, n);
      wait_for(0, n);
      repeat (k) @(posedge mclk);
      node.drive(1'b0);
      wait_for(1, n);
      wait_for(0, d);
      sum += d;
      mn = (d < mn) ? d : mn;
      mx = (d > mx) ? d : mx;
      wait_for(0, n);
      check(n, 6);
      check({31'h0, sample_bit}, 32'h0);
      s0 = n_sync;
      node.drive(1'b1);
      repeat (3) wait_for(0, n);
      check(n_sync - s0, 0);
    end
    // spike from the first pre buffer quantum lasting prop + pre buffer;
    // filtered only when the jump covers its phase error
    wait_for(0, n);
    node.drive(1'b0);
    repeat (2) @(posedge mclk);
    node.drive(1'b1);
    wait_for(0, n);
    check({31'h0, sample_bit}, {31'h0, spk});
    check(sum, es);
    check(mn, emn);
    check(mx, emx);
  endtask : t_sweep

  initial begin
    mclk = 1'b0;
    rstn = 1'b0;
    hard_sync_sel = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    n_mismatch = 0;
    checked = 0;
    n_sync = 0;
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    t_regs();
    t_period(5'h00);
    t_period(5'h1f);
    t_sweep(32'h0001_1020, 1'b0, 17, 2, 3, 1'b1);
    t_sweep(32'h0001_1000, 1'b0, 16, 1, 4, 1'b0);
    t_sweep(32'h0001_1020, 1'b1, 18, 3, 3, 1'b1);
    conclude();
  end
endmodule : tb
